// ### hdl/smsp_pkg.sv
// Purpose: Types of the serial memory SPI slave front end
// Assumes: smsp_regs.svh holds the numeric constants
// Notes:   One packed struct carries all state of the top module except the memory array
`include "smsp_regs.svh"
`default_nettype none

package smsp_pkg;

   // Gray codes along idle, opcode, address, data; ignore hangs off data
   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_OPC    = 3'h1,
      ST_ADDR   = 3'h3,
      ST_DATA   = 3'h2,
      ST_IGNORE = 3'h6
   } smsp_st_t;

   typedef struct packed {
      logic wp_n;
      logic hold_n;
      logic si;
      logic cs_n;
      logic sck;
   } smsp_pins_t;

   typedef struct packed {
      logic sck_q;
      logic cs_n_q;
      logic mode3;
      smsp_st_t st;
      logic [7:0] opc;
      logic [2:0] bit_cnt;
      logic [7:0] shin;
      logic addr_lo;
      logic [`SMSP_ADDR_W-1:0] addr;
      logic [7:0] shout;
      logic rd_act;
      logic so;
      logic so_oe;
      logic so_live;
      logic wel;
      logic wel_clr;
      logic wpen;
      logic [1:0] bp;
   } smsp_state_t;

endpackage : smsp_pkg

`default_nettype wire

// ### hdl/smsp_regs.svh
// Purpose: Constants of the serial memory SPI slave front end
// Assumes: Included by the package, smsp_top and the bench
// Notes:   Definitions only
`ifndef SMSP_REGS_SVH
`define SMSP_REGS_SVH

// Command codes
`define SMSP_CMD_SET_WRITE_LATCH   8'h06
`define SMSP_CMD_CLEAR_WRITE_LATCH 8'h04
`define SMSP_CMD_READ_STATUS       8'h05
`define SMSP_CMD_WRITE_STATUS      8'h01
`define SMSP_CMD_READ_MEM          8'h03
`define SMSP_CMD_WRITE_MEM         8'h02

// Memory geometry
`define SMSP_ADDR_W     11
`define SMSP_MEM_DEPTH  2048
`define SMSP_ADDR_HI_W  3
`define SMSP_ADDR_ONE   11'h001

// Bit counter
`define SMSP_BIT_LAST   3'h7
`define SMSP_BIT_ONE    3'h1

// Status register layout
`define SMSP_SR_WPEN    7
`define SMSP_SR_BP1     3
`define SMSP_SR_BP0     2
`define SMSP_SR_WEL     1

// Block protection codes and boundaries
`define SMSP_BP_NONE    2'h0
`define SMSP_BP_QUARTER 2'h1
`define SMSP_BP_HALF    2'h2
`define SMSP_BP_ALL     2'h3
`define SMSP_QUARTER_HI 2'h3

// Synchroniser reset levels, order {wp_n, hold_n, si, cs_n, sck}
`define SMSP_SYNC_RST   5'h1E
`define SMSP_PIN_N      5

`endif

// ### hdl/smsp_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to i_core_clk
// Notes:   First stage feeds only the second stage
`default_nettype none

module smsp_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         meta_q <= RST_VAL;
         o_sync <= RST_VAL;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule : smsp_sync

`default_nettype wire

// ### hdl/smsp_top.sv
// Purpose: SPI slave front end of a 2K x 8 serial memory with status register
// Assumes: Serial clock is oversampled by i_core_clk (at least 4x faster)
// Notes:   All pins pass two flip-flops; data out changes on serial clock falls
`include "smsp_regs.svh"
`default_nettype none

module smsp_top (
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_si,
   input wire logic i_hold_n,
   input wire logic i_wp_n,
   output logic o_so,
   output logic o_so_oe,
   output logic o_mode3
);
   import smsp_pkg::*;

   smsp_pins_t pin_s;
   smsp_state_t q;
   smsp_state_t d;
   logic [7:0] mem [`SMSP_MEM_DEPTH];
   logic mem_we;
   logic [`SMSP_ADDR_W-1:0] mem_wa;
   logic [7:0] mem_wd;

   // Pins cross into the core clock through two flops each
   smsp_sync #(
      .WIDTH(`SMSP_PIN_N),
      .RST_VAL(`SMSP_SYNC_RST)
   ) u_sync (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .i_async({i_wp_n, i_hold_n, i_si, i_cs_n, i_sck}),
      .o_sync(pin_s)
   );

   function automatic logic [7:0] status_byte(input smsp_state_t s);
      logic [7:0] r;
      r = 8'h00;
      r[`SMSP_SR_WPEN] = s.wpen;
      r[`SMSP_SR_BP1] = s.bp[1];
      r[`SMSP_SR_BP0] = s.bp[0];
      r[`SMSP_SR_WEL] = s.wel;
      return r;
   endfunction : status_byte

   function automatic logic blocked(input logic [1:0] bp, input logic [`SMSP_ADDR_W-1:0] a);
      logic b;
      case (bp)
         `SMSP_BP_QUARTER: b = (a[`SMSP_ADDR_W-1 -: 2] == `SMSP_QUARTER_HI);
         `SMSP_BP_HALF: b = a[`SMSP_ADDR_W-1];
         `SMSP_BP_ALL: b = 1'b1;
         default: b = 1'b0;
      endcase
      return b;
   endfunction : blocked

   logic sck_rise;
   logic sck_fall;
   logic cs_fall;
   logic [7:0] nb;
   logic [`SMSP_ADDR_W-1:0] full_addr;

   always_comb begin
      d = q;
      mem_we = 1'b0;
      mem_wa = q.addr;
      mem_wd = 8'h00;
      sck_rise = pin_s.sck & ~q.sck_q;
      sck_fall = ~pin_s.sck & q.sck_q;
      cs_fall = q.cs_n_q & ~pin_s.cs_n;
      nb = {q.shin[6:0], pin_s.si};
      full_addr = {q.addr[`SMSP_ADDR_W-1 -: `SMSP_ADDR_HI_W], nb};
      // Edges seen during hold are absorbed, so they never act later
      d.sck_q = pin_s.sck;
      d.cs_n_q = pin_s.cs_n;
      if (pin_s.hold_n) begin
         if (pin_s.cs_n) begin
            // Deselect ends any command and drops a partial byte
            if (q.wel_clr) begin
               d.wel = 1'b0;
            end
            d.st = ST_IDLE;
            d.bit_cnt = 3'h0;
            d.rd_act = 1'b0;
            d.wel_clr = 1'b0;
            d.so_live = 1'b0;
            d.opc = 8'h00;
         end else if (cs_fall) begin
            d.mode3 = pin_s.sck;
            d.st = ST_OPC;
            d.bit_cnt = 3'h0;
            d.so_live = 1'b0;
            d.rd_act = 1'b0;
            d.wel_clr = 1'b0;
         end else if (q.st != ST_IDLE && q.st != ST_IGNORE) begin
            // Mode 3 needs no special case: a rise only follows a fall
            if (sck_rise) begin
               d.shin = nb;
               d.bit_cnt = 3'(q.bit_cnt + `SMSP_BIT_ONE);
               if (q.bit_cnt == `SMSP_BIT_LAST) begin
                  case (q.st)
                     ST_OPC: begin
                        d.opc = nb;
                        case (nb)
                           `SMSP_CMD_SET_WRITE_LATCH: begin
                              d.wel = 1'b1;
                              d.st = ST_IGNORE;
                           end
                           `SMSP_CMD_CLEAR_WRITE_LATCH: begin
                              d.wel = 1'b0;
                              d.st = ST_IGNORE;
                           end
                           `SMSP_CMD_READ_STATUS: begin
                              d.shout = status_byte(q);
                              d.rd_act = 1'b1;
                              d.st = ST_DATA;
                           end
                           `SMSP_CMD_WRITE_STATUS: begin
                              d.wel_clr = 1'b1;
                              d.st = ST_DATA;
                           end
                           `SMSP_CMD_READ_MEM: begin
                              d.addr_lo = 1'b0;
                              d.st = ST_ADDR;
                           end
                           `SMSP_CMD_WRITE_MEM: begin
                              d.wel_clr = 1'b1;
                              d.addr_lo = 1'b0;
                              d.st = ST_ADDR;
                           end
                           default: begin
                              d.st = ST_IGNORE;
                           end
                        endcase
                     end
                     ST_ADDR: begin
                        if (!q.addr_lo) begin
                           // Upper five bits of the first byte are dropped
                           d.addr[`SMSP_ADDR_W-1 -: `SMSP_ADDR_HI_W] = nb[`SMSP_ADDR_HI_W-1:0];
                           d.addr_lo = 1'b1;
                        end else begin
                           d.st = ST_DATA;
                           d.addr = full_addr;
                           if (q.opc == `SMSP_CMD_READ_MEM) begin
                              d.shout = mem[full_addr];
                              d.rd_act = 1'b1;
                              d.addr = `SMSP_ADDR_W'(full_addr + `SMSP_ADDR_ONE);
                           end
                        end
                     end
                     ST_DATA: begin
                        case (q.opc)
                           `SMSP_CMD_WRITE_MEM: begin
                              // Write lands in the same cycle the byte completes
                              mem_we = q.wel & ~blocked(q.bp, q.addr);
                              mem_wd = nb;
                              d.addr = `SMSP_ADDR_W'(q.addr + `SMSP_ADDR_ONE);
                           end
                           `SMSP_CMD_READ_MEM: begin
                              d.shout = mem[q.addr];
                              d.addr = `SMSP_ADDR_W'(q.addr + `SMSP_ADDR_ONE);
                           end
                           `SMSP_CMD_READ_STATUS: begin
                              d.shout = status_byte(q);
                           end
                           `SMSP_CMD_WRITE_STATUS: begin
                              if (q.wel && !(q.wpen && !pin_s.wp_n)) begin
                                 d.wpen = nb[`SMSP_SR_WPEN];
                                 d.bp = {nb[`SMSP_SR_BP1], nb[`SMSP_SR_BP0]};
                              end
                              d.st = ST_IGNORE;
                           end
                           default: begin
                              d.st = ST_IGNORE;
                           end
                        endcase
                     end
                     default: begin
                        d.st = ST_IGNORE;
                     end
                  endcase
               end
            end
            if (sck_fall && q.rd_act) begin
               d.so = q.shout[7];
               d.so_live = 1'b1;
               d.shout = {q.shout[6:0], 1'b0};
            end
         end
      end
      // Output enable drops at once on hold or deselect
      // It waits for the first fall of a read, so no stale bit shows after a rise
      d.so_oe = d.rd_act & d.so_live & pin_s.hold_n & ~pin_s.cs_n;
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         q <= '{cs_n_q: 1'b1, st: ST_IDLE, default: '0};
      end else begin
         q <= d;
      end
   end

   // Array holds no reset: contents are meant to persist
   always_ff @(posedge i_core_clk) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   assign o_so = q.so;
   assign o_so_oe = q.so_oe;
   assign o_mode3 = q.mode3;
endmodule : smsp_top

`default_nettype wire

// ### verif/smsp_properties.sv
// Purpose: Port-level checks of the serial memory front end
// Assumes: Pins change off the core clock's rising edge
// Notes:   Windows allow for the two-flop pin synchronisers
`default_nettype none

module smsp_chk (
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_si,
   input wire logic i_hold_n,
   input wire logic i_wp_n,
   input wire logic o_so,
   input wire logic o_so_oe,
   input wire logic o_mode3
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rstn);
   a_deselect_quiet: assert property (i_cs_n [*6] |-> !o_so_oe)
      else $error("output driven while deselected");
   a_hold_quiet: assert property (!i_hold_n [*6] |-> !o_so_oe)
      else $error("output driven during hold");
   a_oe_needs_select: assert property (o_so_oe |-> !$past(i_cs_n, 5))
      else $error("output driven without select");
   a_oe_on_fall: assert property ($rose(o_so_oe) |-> !$past(i_sck, 2))
      else $error("output enabled away from a clock fall");
   a_so_on_fall: assert property (o_so_oe && $past(o_so_oe) && $changed(o_so) |-> !$past(i_sck, 2))
      else $error("output bit changed away from a clock fall");
   a_mode_zero: assert property ($fell(i_cs_n) && !i_sck && i_hold_n |-> ##[2:5] !o_mode3)
      else $error("low clock at select did not give mode 0");
   a_mode_three: assert property ($fell(i_cs_n) && i_sck && i_hold_n |-> ##[2:5] o_mode3)
      else $error("high clock at select did not give mode 3");
   a_mode_steady: assert property ($changed(o_mode3) |-> !$past(i_cs_n, 2))
      else $error("mode changed without a select");
endmodule : smsp_chk

bind smsp_top smsp_chk chk_u (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_sck(i_sck), .i_cs_n(i_cs_n),
   .i_si(i_si), .i_hold_n(i_hold_n), .i_wp_n(i_wp_n), .o_so(o_so), .o_so_oe(o_so_oe), .o_mode3(o_mode3));

`default_nettype wire

// ### verif/smsp_spi_master.sv
// Purpose: Behavioural SPI bus master facing the memory front end
// Assumes: Core clock falling edges pace every pin change
// Notes:   Serial clock of 80 ns runs only inside frames
`default_nettype none

module smsp_spi_master (
   input wire logic i_core_clk,
   input wire logic i_so,
   input wire logic i_so_oe,
   output logic o_sck,
   output logic o_cs_n,
   output logic o_si,
   output logic o_hold_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic m3_q = 1'b0;
   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_si = 1'b0;
      o_hold_n = 1'b1;
   end
   task automatic half();
      repeat (4) @(negedge i_core_clk);
   endtask : half
   // Clock parked at the mode level; caller keeps the power-up wait
   task automatic sel(input logic m3);
      m3_q = m3;
      o_sck = m3;
      half();
      o_cs_n = 1'b0;
      half();
   endtask : sel
   // MSB first, 40 ns phases stay under 20 MHz; unknown read back while undriven
   task automatic xb(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         o_sck = 1'b0;
         o_si = tx[i];
         half();
         o_sck = 1'b1;
         half();
         rx = {rx[6:0], i_so_oe ? i_so : 1'bx};
      end
   endtask : xb
   // Released data line shows the inverse of its last level
   task automatic desel();
      o_sck = m3_q;
      half();
      o_cs_n = 1'b1;
      o_si = ~o_si;
      half();
   endtask : desel
   // Hold moves only while the clock is low
   task automatic hold(input logic lvl);
      o_sck = 1'b0;
      half();
      o_hold_n = lvl;
      half();
   endtask : hold
endmodule : smsp_spi_master

`default_nettype wire

// ### verif/tb_top.sv
// Purpose: Self-checking bench of the serial memory front end
// Assumes: Master model paces the serial pins from the core clock
// Notes:   Write protect driven low only in the protection test; memory protection tested via block bits, status protection via WPEN and the pin
`include "smsp_regs.svh"
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   localparam int powerup_wait = 4;
   logic wp_n = 1'b1;
   logic sck, cs_n, si, hold_n, so, so_oe, mode3;
   logic oe_seen = 1'b0;
   logic [7:0] r;
   int err_total = 0;
   int n_tests = 0;
   always #5 clk = ~clk;
   always @(posedge clk) if (so_oe === 1'b1) oe_seen <= 1'b1;
   smsp_top dut_u (.i_core_clk(clk), .i_rstn(rstn), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
      .i_hold_n(hold_n), .i_wp_n(wp_n), .o_so(so), .o_so_oe(so_oe), .o_mode3(mode3));
   smsp_spi_master m_u (.i_core_clk(clk), .i_so(so), .i_so_oe(so_oe), .o_sck(sck), .o_cs_n(cs_n),
      .o_si(si), .o_hold_n(hold_n));
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic one(input logic m3, input logic [7:0] c, input int n, input logic [7:0] d);
      m_u.sel(m3);
      m_u.xb(c, 8, r);
      m_u.xb(d, n, r);
      m_u.desel();
   endtask : one
   task automatic acc(input logic m3, input logic [7:0] c, input logic [15:0] a);
      m_u.sel(m3);
      m_u.xb(c, 8, r);
      m_u.xb(a[15:8], 8, r);
      m_u.xb(a[7:0], 8, r);
   endtask : acc
   task automatic status(input logic [7:0] exp);
      m_u.sel(1'b0);
      m_u.xb(`SMSP_CMD_READ_STATUS, 8, r);
      m_u.xb(8'h00, 8, r);
      m_u.desel();
      chk(r, exp);
   endtask : status
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      acc(1'b0, `SMSP_CMD_READ_MEM, a);
      m_u.xb(8'h00, 8, r);
      m_u.desel();
      chk(r, exp);
   endtask : rd
   task automatic t_latch();
      one(1'b0, `SMSP_CMD_SET_WRITE_LATCH, 0, 8'h00);
      status(8'h02);
      one(1'b1, `SMSP_CMD_CLEAR_WRITE_LATCH, 0, 8'h00);
      status(8'h00);
   endtask : t_latch
   task automatic t_seq(input logic m3, input logic [7:0] d);
      one(m3, `SMSP_CMD_SET_WRITE_LATCH, 0, 8'h00);
      acc(m3, `SMSP_CMD_WRITE_MEM, 16'hF7FF);
      m_u.xb(d, 8, r);
      m_u.xb(~d, 8, r);
      m_u.desel();
      status(8'h00);
      acc(m3, `SMSP_CMD_READ_MEM, 16'h07FF);
      chk({7'h00, mode3}, {7'h00, m3});
      m_u.xb(8'h00, 8, r);
      chk(r, d);
      m_u.xb(8'h00, 8, r);
      chk(r, ~d);
      m_u.desel();
      chk({7'h00, so_oe}, 8'h00);
   endtask : t_seq
   task automatic t_bad();
      oe_seen = 1'b0;
      acc(1'b0, 8'hFF, {`SMSP_CMD_READ_MEM, 8'h00});
      m_u.xb(8'h00, 8, r);
      m_u.desel();
      chk({7'h00, oe_seen}, 8'h00);
      rd(16'h0000, 8'hA5);
   endtask : t_bad
   task automatic t_abort();
      one(1'b0, `SMSP_CMD_SET_WRITE_LATCH, 0, 8'h00);
      acc(1'b0, `SMSP_CMD_WRITE_MEM, 16'h0000);
      m_u.xb(8'h11, 4, r);
      m_u.desel();
      rd(16'h0000, 8'hA5);
   endtask : t_abort
   task automatic t_prot();
      one(1'b0, `SMSP_CMD_SET_WRITE_LATCH, 0, 8'h00);
      one(1'b0, `SMSP_CMD_WRITE_STATUS, 8, 8'hFF);
      status(8'h8C);
      one(1'b0, `SMSP_CMD_SET_WRITE_LATCH, 0, 8'h00);
      acc(1'b0, `SMSP_CMD_WRITE_MEM, 16'h07FF);
      m_u.xb(8'h00, 8, r);
      m_u.desel();
      rd(16'h07FF, 8'h5A);
      // Write protect pin low with protection enabled refuses a status write
      wp_n = 1'b0;
      one(1'b0, `SMSP_CMD_SET_WRITE_LATCH, 0, 8'h00);
      one(1'b0, `SMSP_CMD_WRITE_STATUS, 8, 8'h00);
      status(8'h8C);
      wp_n = 1'b1;
      one(1'b0, `SMSP_CMD_SET_WRITE_LATCH, 0, 8'h00);
      one(1'b0, `SMSP_CMD_WRITE_STATUS, 8, 8'h00);
      status(8'h00);
   endtask : t_prot
   task automatic t_hold();
      acc(1'b0, `SMSP_CMD_READ_MEM, 16'h07FF);
      m_u.hold(1'b0);
      repeat (2) @(negedge clk);
      chk({7'h00, so_oe}, 8'h00);
      m_u.hold(1'b1);
      repeat (2) @(negedge clk);
      chk({7'h00, so_oe}, 8'h01);
      m_u.xb(8'h00, 8, r);
      m_u.desel();
      chk(r, 8'h5A);
   endtask : t_hold
   initial begin
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      repeat (powerup_wait) @(negedge clk);
      t_latch();
      t_seq(1'b0, 8'hA5);
      t_seq(1'b1, 8'h5A);
      t_bad();
      t_abort();
      t_prot();
      t_hold();
      summarize();
   end
   // Whole run is near 54 us; a hang beyond this is a failure
   initial begin
      #300us;
      err_total++;
      summarize();
   end
endmodule : tb_top

`default_nettype wire
